// ===== rtl/ccs_core_timing.sv
// Core cycle phases, instruction sequencing, stretch and power control
`timescale 1ns/1ps
`default_nettype none
module ccs_core_timing (
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_resetn,
    // Special function register port
    input  wire logic [7:0]                    i_sfr_addr,
    input  wire logic                          i_sfr_wr,
    input  wire logic                          i_sfr_rd,
    input  wire logic [7:0]                    i_sfr_wdata,
    output logic      [7:0]                    o_sfr_rdata,
    // Instruction issue
    input  wire logic                          i_instr_valid,
    input  wire logic [2:0]                    i_instr_len,
    input  wire logic                          i_instr_xmove,
    output logic                               o_instr_ready,
    // Interrupt levels
    input  wire logic [ccs_pkg::INT_LINES-1:0] i_int_level,
    input  wire logic [ccs_pkg::INT_LINES-1:0] i_int_enable,
    output logic      [ccs_pkg::INT_LINES-1:0] o_int_sampled,
    // Timing outputs
    output logic      [3:0]                    o_phase,
    output logic                               o_fetch_done,
    output logic                               o_exec,
    output logic                               o_write,
    output logic                               o_xmove_busy,
    // Power control and timer
    input  wire logic                          i_timer_fast,
    output logic                               o_timer_tick,
    output logic                               o_idle,
    output logic                               o_baud_double
);
    import ccs_pkg::*;

    logic [1:0] phase_q;
    logic [3:0] left_q;
    logic       stage1_q;
    logic       stage2_q;
    logic       xm_q;
    logic [7:0] power_control_q;
    logic [2:0] stretch_q;

    function automatic logic [3:0] instr_cycles(input logic xm,
                                                input logic [2:0] len,
                                                input logic [2:0] st);
        if (xm)
            instr_cycles = XMOVE_BASE_CYCLES + {1'b0, st};
        else if (len == 3'h0)
            instr_cycles = 4'h1;
        else if (len > INSTR_MAX_CYCLES)
            instr_cycles = {1'b0, INSTR_MAX_CYCLES};
        else
            instr_cycles = {1'b0, len};
    endfunction : instr_cycles

    wire       wr_power_control  = i_sfr_wr && (i_sfr_addr == ADDR_POWER_CONTROL);
    wire       wr_strch = i_sfr_wr && (i_sfr_addr == ADDR_CLOCK_STRETCH);
    wire       wake     = |(i_int_level & i_int_enable);
    wire       idle     = power_control_q[BIT_IDLE];
    wire       adv      = !idle;
    wire       bound    = adv && (phase_q == PHASE_LAST);
    wire       finish   = bound && (left_q == 4'h1);
    wire       can_take = (left_q == 4'h0) || (left_q == 4'h1);
    wire       take     = bound && can_take && i_instr_valid;
    wire [3:0] new_len  = instr_cycles(i_instr_xmove, i_instr_len, stretch_q);
    wire [3:0] left_d   = take ? new_len
                        : (bound && left_q != 4'h0) ? left_q - 4'h1
                        : left_q;
    wire [7:0] power_control_wr  = i_sfr_wdata & 8'h8f;
    wire [7:0] power_control_d   = wr_power_control ? power_control_wr : power_control_q;
    wire [7:0] power_control_n   = (idle && wake) ? (power_control_d & 8'hfe) : power_control_d;
    wire [7:0] rd_mux   = (i_sfr_addr == ADDR_POWER_CONTROL) ? power_control_q
                        : (i_sfr_addr == ADDR_CLOCK_STRETCH)
                          ? {5'h00, stretch_q} : 8'h00;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_q <= 2'h0;
            o_phase <= 4'h1;
        end else if (adv) begin
            phase_q <= phase_q + 2'h1;
            o_phase <= {o_phase[2:0], o_phase[3]};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            left_q        <= 4'h0;
            xm_q          <= 1'b0;
            o_instr_ready <= 1'b1;
            o_fetch_done  <= 1'b0;
        end else begin
            left_q        <= left_d;
            xm_q          <= take ? i_instr_xmove
                           : (left_d == 4'h0) ? 1'b0 : xm_q;
            o_instr_ready <= (left_d <= 4'h1);
            o_fetch_done  <= finish;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            o_exec   <= 1'b0;
            o_write  <= 1'b0;
        end else begin
            if (bound) begin
                stage1_q <= finish;
                stage2_q <= stage1_q;
            end
            o_exec  <= bound && stage1_q;
            o_write <= bound && stage2_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            o_int_sampled <= '0;
        else if (adv && phase_q == PHASE_SAMPLE)
            o_int_sampled <= i_int_level;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            power_control_q        <= POWER_CONTROL_RESET;
            stretch_q     <= STRETCH_RESET;
            o_idle        <= 1'b0;
            o_baud_double <= 1'b0;
            o_sfr_rdata   <= 8'h00;
            o_xmove_busy  <= 1'b0;
        end else begin
            power_control_q        <= power_control_n;
            if (wr_strch)
                stretch_q <= i_sfr_wdata[2:0];
            o_idle        <= power_control_n[BIT_IDLE];
            o_baud_double <= power_control_n[BIT_BAUD_DOUBLE];
            if (i_sfr_rd)
                o_sfr_rdata <= rd_mux;
            o_xmove_busy  <= (left_d != 4'h0) &&
                             (take ? i_instr_xmove : xm_q);
        end
    end

    ccs_tick_div u_tick (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_fast   (i_timer_fast),
        .o_tick   (o_timer_tick)
    );

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_phase_ring;
        adv |=> (phase_q == $past(phase_q) + 2'h1);
    endproperty
    a_phase_ring: assert property (p_phase_ring)
        else $error("phase did not advance");

    property p_exec_follow;
        o_fetch_done |-> ##[1:4] (bound && stage1_q) or idle;
    endproperty
    a_exec_follow: assert property (p_exec_follow)
        else $error("exec not in next instruction cycle");

    property p_write_after_exec;
        o_write |-> $past(stage2_q) && !idle;
    endproperty
    a_write_after_exec: assert property (p_write_after_exec)
        else $error("write without prior exec stage");

    property p_int_sample;
        (adv && phase_q == PHASE_SAMPLE) |=> o_int_sampled == $past(i_int_level);
    endproperty
    a_int_sample: assert property (p_int_sample)
        else $error("interrupt not sampled at third phase end");

    property p_xmove_len;
        (take && i_instr_xmove) |=>
            left_q == 4'h2 + {1'b0, $past(stretch_q)};
    endproperty
    a_xmove_len: assert property (p_xmove_len)
        else $error("move length not two plus stretch");

    property p_len_range;
        take |=> (left_q >= 4'h1) && (left_q <= 4'h9);
    endproperty
    a_len_range: assert property (p_len_range)
        else $error("instruction length out of range");

    property p_stretch_wr;
        wr_strch |=> stretch_q == $past(i_sfr_wdata[2:0]);
    endproperty
    a_stretch_wr: assert property (p_stretch_wr)
        else $error("stretch write not applied");

    property p_idle_halts;
        idle && !wake |=> $stable(phase_q) && !o_exec && !o_write;
    endproperty
    a_idle_halts: assert property (p_idle_halts)
        else $error("execution while idle");

    property p_wake_clear;
        idle && wake |=> !power_control_q[BIT_IDLE] ##1 !o_idle;
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("idle bit not cleared by wakeup");

    property p_baud;
        ##1 o_baud_double == $past(power_control_n[BIT_BAUD_DOUBLE]);
    endproperty
    a_baud: assert property (p_baud)
        else $error("baud double not following register");

    c_xmove: cover property (take && i_instr_xmove && stretch_q == 3'h7);
    c_wake:  cover property (idle && wake);
    c_write: cover property (o_write);
endmodule : ccs_core_timing
`default_nettype wire

// ===== rtl/ccs_pkg.sv
// Constants for the cycle stretch, timing and idle control block
package ccs_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_CLOCK_STRETCH = 8'h8e;
    localparam int         BIT_IDLE           = 0;
    localparam int         BIT_RSVD1          = 1;
    localparam int         BIT_FLAG_LO        = 2;
    localparam int         BIT_FLAG_HI        = 3;
    localparam int         BIT_BAUD_DOUBLE    = 7;
    localparam logic [7:0] POWER_CONTROL_RESET         = 8'h00;
    localparam logic [2:0] STRETCH_RESET      = 3'h1;
    localparam logic [1:0] PHASE_LAST         = 2'h3;
    localparam logic [1:0] PHASE_SAMPLE       = 2'h2;
    localparam logic [2:0] INSTR_MAX_CYCLES   = 3'h5;
    localparam logic [3:0] XMOVE_BASE_CYCLES  = 4'h2;
    localparam logic [3:0] TIMER_SLOW_CLOCKS  = 4'hc;
    localparam logic [3:0] TIMER_FAST_CLOCKS  = 4'h4;
    localparam int         INT_LINES          = 4;
endpackage : ccs_pkg

// ===== rtl/ccs_tick_div.sv
// Timer increment rate divider
`timescale 1ns/1ps
`default_nettype none
module ccs_tick_div (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // Control
    input  wire logic i_fast,
    // Tick
    output logic      o_tick
);
    import ccs_pkg::*;
    logic [3:0] cnt_q;
    wire  [3:0] period = i_fast ? TIMER_FAST_CLOCKS : TIMER_SLOW_CLOCKS;
    wire        wrap   = (cnt_q >= period - 4'h1);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q  <= 4'h0;
            o_tick <= 1'b0;
        end else begin
            cnt_q  <= wrap ? 4'h0 : cnt_q + 4'h1;
            o_tick <= wrap;
        end
    end
endmodule : ccs_tick_div
`default_nettype wire

// ===== verif/ccs_xmem_model.sv
// Slow external data memory model timing each external move
`timescale 1ns/1ps
`default_nettype none
module ccs_xmem_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Move strobe from the core
    input  wire logic       i_busy,
    // Length of the last finished move in clocks
    output logic      [7:0] o_busy_len
);
    logic [7:0] cnt_q;
    // Memory holds the bus for as long as the core stretches the move
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q      <= 8'h00;
            o_busy_len <= 8'h00;
        end else if (i_busy) begin
            cnt_q <= cnt_q + 8'h01;
        end else if (cnt_q != 8'h00) begin
            o_busy_len <= cnt_q;
            cnt_q      <= 8'h00;
        end
    end
endmodule : ccs_xmem_model
`default_nettype wire

// ===== verif/cpu_cycle_stretch_idle_tb.sv
// Testbench for the cycle timing, stretch and power control block
`timescale 1ns/1ps
`default_nettype none
module cpu_cycle_stretch_idle_tb;
    import ccs_pkg::*;
    logic clk, rstn, wr, rd, vld, xm, fast;
    logic [7:0] addr, wdat, rdat, blen;
    logic [2:0] len;
    logic [3:0] lvl, ena, smp, ph;
    logic rdy, fd, ex, wrt, busy, tick, idle, baud;
    int num_errors, checks_done, n;
    int st[3] = '{0, 7, 3};
    ccs_core_timing ccs_core_timing_inst (
        .i_clk(clk), .i_resetn(rstn), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdat), .o_sfr_rdata(rdat),
        .i_instr_valid(vld), .i_instr_len(len), .i_instr_xmove(xm),
        .o_instr_ready(rdy), .i_int_level(lvl), .i_int_enable(ena),
        .o_int_sampled(smp), .o_phase(ph), .o_fetch_done(fd), .o_exec(ex),
        .o_write(wrt), .o_xmove_busy(busy), .i_timer_fast(fast),
        .o_timer_tick(tick), .o_idle(idle), .o_baud_double(baud));
    ccs_xmem_model ccs_xmem_model_inst (
        .i_clk(clk), .i_resetn(rstn), .i_busy(busy), .o_busy_len(blen));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic test_done;
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic wreg(input logic [7:0] a, d);
        step();
        addr = a; wdat = d; wr = 1'b1;
        step();
        wr = 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, e);
        step();
        addr = a; rd = 1'b1;
        step();
        rd = 1'b0;
        chk("sfr_rdata", rdat, e);
    endtask : rreg
    task automatic run(input logic [2:0] l, input logic x, input int e);
        while (!(ph[3] === 1'b1 && rdy === 1'b1)) step();
        vld = 1'b1; len = l; xm = x;
        step();
        vld = 1'b0; n = 0;
        chk("instr_ready", {7'h0, rdy}, 8'(e == 4));
        while (fd !== 1'b1 && n < 200) begin step(); n++; end
        chk("fetch_cycles", 8'(n), 8'(e));
    endtask : run
    task automatic gap(input logic f, input int e);
        fast = f;
        repeat (2) begin
            n = 0;
            do begin step(); n++; end while (tick !== 1'b1 && n < 40);
        end
        chk("tick_gap", 8'(n), 8'(e));
    endtask : gap
    initial begin
        #100us;
        num_errors++;
        test_done();
    end
    initial begin
        {rstn, wr, rd, vld, xm, fast} = '0;
        {addr, wdat, len, lvl, ena} = '0;
        num_errors = 0; checks_done = 0;
        repeat (4) @(posedge clk);
        #1;
        chk("phase_reset", {4'h0, ph}, 8'h01);
        chk("ready_reset", {7'h0, rdy}, 8'h01);
        rstn = 1'b1;
        rreg(ADDR_POWER_CONTROL, POWER_CONTROL_RESET);
        rreg(ADDR_CLOCK_STRETCH, {5'h00, STRETCH_RESET});
        rreg(8'h88, 8'h00);
        repeat (8) begin
            wdat = {4'h0, ph[2:0], ph[3]};
            step();
            chk("phase", {4'h0, ph}, wdat);
        end
        run(3'h1, 1'b0, 4);
        n = 0;
        while (ex !== 1'b1 && n < 20) begin step(); n++; end
        chk("exec_gap", 8'(n), 8'h04);
        n = 0;
        while (wrt !== 1'b1 && n < 20) begin step(); n++; end
        chk("write_gap", 8'(n), 8'h04);
        run(3'h3, 1'b0, 12);
        run(3'h5, 1'b0, 20);
        run(3'h0, 1'b0, 4);
        run(3'h7, 1'b0, 20);
        run(3'h0, 1'b1, 12);
        foreach (st[i]) begin
            // Upper bits set to show only the low three count
            wreg(ADDR_CLOCK_STRETCH, 8'hf8 | 8'(st[i]));
            run(3'h0, 1'b1, (2 + st[i]) * 4);
            step();
            chk("move_busy", blen, 8'((2 + st[i]) * 4));
        end
        // New level shown only during the third phase
        while (ph[2] !== 1'b1) step();
        lvl = 4'h5;
        while (ph[3] !== 1'b1) step();
        chk("int_sampled", {4'h0, smp}, 8'h05);
        lvl = 4'ha;
        step();
        chk("int_sampled", {4'h0, smp}, 8'h05);
        lvl = 4'h0;
        gap(1'b0, 12);
        gap(1'b1, 4);
        wreg(ADDR_POWER_CONTROL, 8'h8c);
        rreg(ADDR_POWER_CONTROL, 8'h8c);
        chk("baud_double", {7'h0, baud}, 8'h01);
        wreg(ADDR_POWER_CONTROL, 8'h70);
        rreg(ADDR_POWER_CONTROL, 8'h00);
        chk("baud_double", {7'h0, baud}, 8'h00);
        wreg(ADDR_POWER_CONTROL, 8'h01);
        step();
        wdat = {4'h0, ph};
        lvl = 4'h2;
        repeat (3) step();
        chk("idle_phase", {4'h0, ph}, wdat);
        chk("idle", {7'h0, idle}, 8'h01);
        ena = 4'h2;
        repeat (3) step();
        chk("idle", {7'h0, idle}, 8'h00);
        rreg(ADDR_POWER_CONTROL, 8'h00);
        test_done();
    end
endmodule : cpu_cycle_stretch_idle_tb
`default_nettype wire
